// file: include/lefr_pkg.sv
// Package for the link event flag register: bit positions, offsets and event carrier.
package lefr_pkg;

  // Register offsets on the plain register port (byte addresses)
  localparam logic [7:0] OFS_FLAGS  = 8'h00;
  localparam logic [7:0] OFS_MASK   = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // Flag bit positions
  localparam int BIT_PHY_RESET   = 3;
  localparam int BIT_SELFID_DONE = 4;
  localparam int BIT_TX_IDLE     = 5;
  localparam int BIT_RX_BLOCK    = 6;
  localparam int BIT_RESET_CMD   = 7;
  localparam int BIT_ACK_RCV     = 8;
  localparam int BIT_ISO_BAD     = 11;
  localparam int BIT_ASYNC_BAD   = 12;
  localparam int BIT_BUSY_ACK    = 14;
  localparam int BIT_HDR_ERR     = 15;

  // Control register bit positions
  localparam int BIT_SELFID_CAPTURE = 1;
  localparam int BIT_TRIGGER_SIZE   = 2;
  localparam int BIT_ASYNC_CLEAR    = 3;

  // Status register bit positions
  localparam int BIT_ERR_STATE   = 0;
  localparam int BIT_IN_SELFID   = 1;
  localparam int BIT_DEFER_RX    = 2;
  localparam int BIT_ACK_VALID   = 31;

  // Values after reset
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET  = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

  // Writable bits of the flag and mask registers
  localparam logic [31:0] FLAG_IMPL = 32'h0000_d9f8;

  // Event pulses from transmitter, receiver and receive queue
  typedef struct packed {
    logic bus_reset_start;
    logic bus_reset_done;
    logic tx_idle;
    logic rx_block;
    logic rx_packet_end;
    logic reset_cmd_write;
    logic ack_or_timeout;
    logic iso_bad_data;
    logic first_not_first;
    logic async_underflow;
    logic queue_overflow;
    logic hdr_crc_error;
  } lefr_evt_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } lefr_req_t;

endpackage

// file: src/lefr_flags.sv
// Event flag register with mask, control and interrupt output of the link controller.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
// Notes on behaviour
// - Set selfid done at bit 4 when bus reset ends; capture enable is control bit 1.
// - Set transmitter idle at bit 5 when transmitter can take a new packet.
// - Idle with ack valid low on non-broadcast async send means lost arbitration; retry.
// - Set receive block at bit 6 per block; a block is a packet when trigger off.
// - During self-ID phase defer receive block flag until bus reset ends.
// - Set reset command flag at bit 7 on quadlet write to reset start register.
// - Set ack received at bit 8 on acknowledge or timeout; mask bit enables it.
// - Set iso transmit bad at bit 11 on invalid iso queue data.
// - First quadlet not via first entry sets async bad bit 12 and error state.
// - Async queue underflow during send also sets async bad and error state.
// - Error state blocks async sends until queue clear bit; iso still sent.
// - Queue overflow sets busy ack sent at bit 14 and forces busy acknowledge.
// - Header CRC error sets bit 15 and discards the packet.
// - Set PHY reset started at bit 3 when a bus reset begins.
module lefr_flags (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // Register port
  input  wire lefr_pkg::lefr_req_t req,
  output logic [31:0]            rdata,
  // Events from the link
  input  wire lefr_pkg::lefr_evt_t evt,
  input  wire logic              ack_valid,
  input  wire logic              async_pending,
  input  wire logic              broadcast,
  // Controls back to the link
  output logic                   async_send_en,
  output logic                   retry_arb,
  output logic                   force_busy_ack,
  output logic                   discard_packet,
  output logic                   async_queue_clear,
  output logic                   selfid_capture_enable,
  output logic                   trigger_size_enable,
  // Interrupt
  output logic                   irq
);

  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] mask;
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic        err_state;
    logic        in_selfid;
    logic        defer_rx;
    logic        retry;
    logic        busy;
    logic        discard;
    logic        clr;
    logic        irq;
    logic        send_en;
  } lefr_state_t;

  lefr_state_t s_q;
  lefr_state_t s_d;

  // Read mux for the register port
  function automatic logic [31:0] rd_mux(input lefr_state_t s, input logic [7:0] a,
                                         input logic av);
    logic [31:0] st;
    st = 32'h0000_0000;
    st[lefr_pkg::BIT_ERR_STATE] = s.err_state;
    st[lefr_pkg::BIT_IN_SELFID] = s.in_selfid;
    st[lefr_pkg::BIT_DEFER_RX]  = s.defer_rx;
    st[lefr_pkg::BIT_ACK_VALID] = av;
    case (a)
      lefr_pkg::OFS_FLAGS:  rd_mux = s.flags;
      lefr_pkg::OFS_MASK:   rd_mux = s.mask;
      lefr_pkg::OFS_CTRL:   rd_mux = s.ctrl;
      lefr_pkg::OFS_STATUS: rd_mux = st;
      default:              rd_mux = 32'h0000_0000;
    endcase
  endfunction

  // One-hot word with a single bit at the given position
  function automatic logic [31:0] onehot(input int pos);
    onehot = 32'h0000_0001 << pos;
  endfunction

  // Next state of flags, mask, control and link controls
  always_comb begin
    logic [31:0] set_v;
    logic [31:0] clr_v;
    logic        rx_now;
    set_v = 32'h0000_0000;
    clr_v = 32'h0000_0000;
    rx_now = 1'b0;
    s_d = s_q;
    s_d.clr = 1'b0;
    // Self-ID phase tracking
    if (evt.bus_reset_start) begin
      s_d.in_selfid = 1'b1;
      set_v[lefr_pkg::BIT_PHY_RESET] = 1'b1;
    end
    // Receive block: per packet when trigger off, per block otherwise
    rx_now = s_q.ctrl[lefr_pkg::BIT_TRIGGER_SIZE] ? evt.rx_block : evt.rx_packet_end;
    if (rx_now && (s_q.in_selfid || evt.bus_reset_start)) begin
      s_d.defer_rx = 1'b1;
    end else if (rx_now) begin
      set_v[lefr_pkg::BIT_RX_BLOCK] = 1'b1;
    end
    if (evt.bus_reset_done) begin
      s_d.in_selfid = 1'b0;
      set_v[lefr_pkg::BIT_SELFID_DONE] = 1'b1;
      if (s_q.defer_rx || rx_now) begin
        set_v[lefr_pkg::BIT_RX_BLOCK] = 1'b1;
      end
      s_d.defer_rx = 1'b0;
    end
    if (evt.tx_idle) set_v[lefr_pkg::BIT_TX_IDLE] = 1'b1;
    if (evt.reset_cmd_write) set_v[lefr_pkg::BIT_RESET_CMD] = 1'b1;
    if (evt.ack_or_timeout) set_v[lefr_pkg::BIT_ACK_RCV] = 1'b1;
    if (evt.iso_bad_data) set_v[lefr_pkg::BIT_ISO_BAD] = 1'b1;
    if (evt.queue_overflow) set_v[lefr_pkg::BIT_BUSY_ACK] = 1'b1;
    if (evt.hdr_crc_error) set_v[lefr_pkg::BIT_HDR_ERR] = 1'b1;
    s_d.busy = evt.queue_overflow;
    s_d.discard = evt.hdr_crc_error;
    // Lost arbitration: idle while ack valid stays low on a directed async send
    s_d.retry = evt.tx_idle && !ack_valid && async_pending && !broadcast;
    // Register writes
    if (req.wr) begin
      case (req.addr)
        lefr_pkg::OFS_FLAGS: clr_v = req.wdata & lefr_pkg::FLAG_IMPL;
        lefr_pkg::OFS_MASK:  s_d.mask = req.wdata & lefr_pkg::FLAG_IMPL;
        lefr_pkg::OFS_CTRL: begin
          // Only the two enable bits are kept; the clear bit reads back as zero
          s_d.ctrl = req.wdata & (onehot(lefr_pkg::BIT_SELFID_CAPTURE)
                                  | onehot(lefr_pkg::BIT_TRIGGER_SIZE));
          s_d.clr = req.wdata[lefr_pkg::BIT_ASYNC_CLEAR];
        end
        default: ;
      endcase
    end
    // Error state of the async transmit path
    if (s_q.clr) s_d.err_state = 1'b0;
    if (evt.first_not_first || evt.async_underflow) begin
      s_d.err_state = 1'b1;
      set_v[lefr_pkg::BIT_ASYNC_BAD] = 1'b1;
    end
    // Send enable is kept in a flop so the output needs no gate after it
    s_d.send_en = !s_d.err_state;
    // Sticky flags, set wins over a write-one clear
    s_d.flags = ((s_q.flags & ~clr_v) | set_v) & lefr_pkg::FLAG_IMPL;
    s_d.irq = |(s_d.flags & s_d.mask);
    s_d.rdata = req.rd ? rd_mux(s_q, req.addr, ack_valid) : 32'h0000_0000;
  end

  // State register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.flags <= lefr_pkg::FLAGS_RESET;
      s_q.mask <= lefr_pkg::MASK_RESET;
      s_q.ctrl <= lefr_pkg::CTRL_RESET;
      s_q.send_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign rdata = s_q.rdata;
  assign irq = s_q.irq;
  assign async_send_en = s_q.send_en;
  assign retry_arb = s_q.retry;
  assign force_busy_ack = s_q.busy;
  assign discard_packet = s_q.discard;
  assign async_queue_clear = s_q.clr;
  assign selfid_capture_enable = s_q.ctrl[lefr_pkg::BIT_SELFID_CAPTURE];
  assign trigger_size_enable = s_q.ctrl[lefr_pkg::BIT_TRIGGER_SIZE];

  // Checks on flag setting: each flag follows its event by one cycle

  // Bus reset start raises the PHY reset flag
  a_phyrst_sets: assert property (@(posedge clock) disable iff (!rstn)
    evt.bus_reset_start |=> s_q.flags[lefr_pkg::BIT_PHY_RESET])
    else $error("phy reset flag");

  // End of bus reset raises self-ID done
  a_selfid_sets: assert property (@(posedge clock) disable iff (!rstn)
    evt.bus_reset_done |=> s_q.flags[lefr_pkg::BIT_SELFID_DONE])
    else $error("selfid flag");

  // Start of bus reset enters the self-ID phase
  a_selfid_enter: assert property (@(posedge clock) disable iff (!rstn)
    (evt.bus_reset_start && !evt.bus_reset_done) |=> s_q.in_selfid)
    else $error("selfid phase");

  // Idle transmitter raises its flag
  a_txidle_sets: assert property (@(posedge clock) disable iff (!rstn)
    evt.tx_idle |=> s_q.flags[lefr_pkg::BIT_TX_IDLE])
    else $error("tx idle flag");

  // Write to the reset start register raises the command flag
  a_rstcmd_sets: assert property (@(posedge clock) disable iff (!rstn)
    evt.reset_cmd_write |=> s_q.flags[lefr_pkg::BIT_RESET_CMD])
    else $error("reset command flag");

  // Acknowledge or timeout raises the ack flag
  a_ack_sets: assert property (@(posedge clock) disable iff (!rstn)
    evt.ack_or_timeout |=> s_q.flags[lefr_pkg::BIT_ACK_RCV])
    else $error("ack flag");

  // With its mask bit on, the ack event reaches the interrupt line
  a_ack_irq: assert property (@(posedge clock) disable iff (!rstn)
    (evt.ack_or_timeout && s_q.mask[lefr_pkg::BIT_ACK_RCV]
     && !(req.wr && req.addr == lefr_pkg::OFS_MASK)) |=> irq)
    else $error("ack interrupt");

  // Bad iso queue data raises its flag
  a_iso_sets: assert property (@(posedge clock) disable iff (!rstn)
    evt.iso_bad_data |=> s_q.flags[lefr_pkg::BIT_ISO_BAD])
    else $error("iso bad flag");

  // Header CRC error raises its flag
  a_hdr_sets: assert property (@(posedge clock) disable iff (!rstn)
    evt.hdr_crc_error |=> s_q.flags[lefr_pkg::BIT_HDR_ERR])
    else $error("header error flag");

  // Checks on the receive block flag
  // Whole packet counts as a block with the trigger size off
  a_rx_packet: assert property (@(posedge clock) disable iff (!rstn)
    (evt.rx_packet_end && !trigger_size_enable && !s_q.in_selfid && !evt.bus_reset_start)
    |=> s_q.flags[lefr_pkg::BIT_RX_BLOCK])
    else $error("rx flag");

  // Each block counts with the trigger size on
  a_rx_block_mode: assert property (@(posedge clock) disable iff (!rstn)
    (evt.rx_block && trigger_size_enable && !s_q.in_selfid && !evt.bus_reset_start)
    |=> s_q.flags[lefr_pkg::BIT_RX_BLOCK])
    else $error("rx block flag");

  // Packet end alone sets nothing with the trigger size on
  a_rx_trig_gate: assert property (@(posedge clock) disable iff (!rstn)
    (evt.rx_packet_end && !evt.rx_block && trigger_size_enable && !evt.bus_reset_done
     && !s_q.flags[lefr_pkg::BIT_RX_BLOCK]) |=> !s_q.flags[lefr_pkg::BIT_RX_BLOCK])
    else $error("rx flag on packet end");

  // No receive flag inside the self-ID phase
  a_rx_deferred: assert property (@(posedge clock) disable iff (!rstn)
    (s_q.in_selfid && !evt.bus_reset_done && !s_q.flags[lefr_pkg::BIT_RX_BLOCK])
    |=> !s_q.flags[lefr_pkg::BIT_RX_BLOCK])
    else $error("rx flag during selfid");

  // A held-back block shows at the end of bus reset
  a_rx_release: assert property (@(posedge clock) disable iff (!rstn)
    (evt.bus_reset_done && s_q.defer_rx) |=> s_q.flags[lefr_pkg::BIT_RX_BLOCK])
    else $error("deferred rx lost");

  // Checks on the async error state
  // Bad first quadlet or underflow blocks async sends
  a_async_block: assert property (@(posedge clock) disable iff (!rstn)
    (evt.first_not_first || evt.async_underflow)
    |=> !async_send_en && s_q.flags[lefr_pkg::BIT_ASYNC_BAD])
    else $error("async error");

  // Underflow alone enters the error state
  a_underflow_err: assert property (@(posedge clock) disable iff (!rstn)
    evt.async_underflow |=> !async_send_en && s_q.flags[lefr_pkg::BIT_ASYNC_BAD])
    else $error("underflow error");

  // Error state holds until the queue clear pulse
  a_err_holds: assert property (@(posedge clock) disable iff (!rstn)
    (!async_send_en && !async_queue_clear) |=> !async_send_en)
    else $error("err left");

  // Queue clear with no new error leaves the error state
  a_err_clears: assert property (@(posedge clock) disable iff (!rstn)
    (async_queue_clear && !evt.first_not_first && !evt.async_underflow) |=> async_send_en)
    else $error("err kept");

  // Queue clear pulse only after a control write
  a_clear_pulse: assert property (@(posedge clock) disable iff (!rstn)
    !(req.wr && req.addr == lefr_pkg::OFS_CTRL) |=> !async_queue_clear)
    else $error("stray queue clear");

  // Checks on the one-cycle link controls
  // Lost arbitration on a directed async send
  a_retry_arb: assert property (@(posedge clock) disable iff (!rstn)
    (evt.tx_idle && !ack_valid && async_pending && !broadcast) |=> retry_arb)
    else $error("retry missing");

  // No retry without an idle transmitter and ack valid low
  a_retry_pulse: assert property (@(posedge clock) disable iff (!rstn)
    (!evt.tx_idle || ack_valid) |=> !retry_arb)
    else $error("stray retry");

  // Overflow forces a busy acknowledge and sets its flag
  a_busy_ack: assert property (@(posedge clock) disable iff (!rstn)
    evt.queue_overflow |=> force_busy_ack && s_q.flags[lefr_pkg::BIT_BUSY_ACK])
    else $error("busy ack");

  // No busy acknowledge without an overflow
  a_busy_pulse: assert property (@(posedge clock) disable iff (!rstn)
    !evt.queue_overflow |=> !force_busy_ack)
    else $error("stray busy ack");

  // Header error discards the packet
  a_hdr_discard: assert property (@(posedge clock) disable iff (!rstn)
    evt.hdr_crc_error |=> discard_packet)
    else $error("discard");

  // No discard without a header error
  a_discard_pulse: assert property (@(posedge clock) disable iff (!rstn)
    !evt.hdr_crc_error |=> !discard_packet)
    else $error("stray discard");

  // Checks on stickiness and the interrupt line
  // Interrupt follows the unmasked flags
  a_irq_level: assert property (@(posedge clock) disable iff (!rstn)
    ##1 irq == |(s_q.flags & s_q.mask))
    else $error("irq level");

  // A flag stays until written with a one
  a_flag_sticky: assert property (@(posedge clock) disable iff (!rstn)
    (s_q.flags[lefr_pkg::BIT_HDR_ERR] && !(req.wr && req.addr == lefr_pkg::OFS_FLAGS))
    |=> s_q.flags[lefr_pkg::BIT_HDR_ERR])
    else $error("flag lost");

  // Set wins over a clear in the same cycle
  a_set_wins: assert property (@(posedge clock) disable iff (!rstn)
    (evt.hdr_crc_error && req.wr && req.addr == lefr_pkg::OFS_FLAGS)
    |=> s_q.flags[lefr_pkg::BIT_HDR_ERR])
    else $error("set lost to clear");

  // Writing a one clears a flag with no new event
  a_clear_works: assert property (@(posedge clock) disable iff (!rstn)
    (req.wr && req.addr == lefr_pkg::OFS_FLAGS && req.wdata[lefr_pkg::BIT_HDR_ERR]
     && !evt.hdr_crc_error) |=> !s_q.flags[lefr_pkg::BIT_HDR_ERR])
    else $error("flag not cleared");

  // Main scenarios
  // Interrupt rises
  c_irq_fire: cover property (@(posedge clock) disable iff (!rstn) $rose(irq));
  // Error state left after a queue clear
  c_err_exit: cover property (@(posedge clock) disable iff (!rstn) $rose(async_send_en));
  // Held-back block released at the end of bus reset
  c_deferred: cover property (@(posedge clock) disable iff (!rstn)
    s_q.defer_rx && evt.bus_reset_done);
  // Event and clear in one cycle
  c_set_clear: cover property (@(posedge clock) disable iff (!rstn)
    evt.hdr_crc_error && req.wr && req.addr == lefr_pkg::OFS_FLAGS);
  // Lost arbitration seen
  c_retry: cover property (@(posedge clock) disable iff (!rstn) retry_arb);

endmodule

// file: verification/lefr_link_model.sv
// Link-side model that sources event pulses and send status for the flag register.
`timescale 1ns/1ps
module lefr_link_model (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rstn,
  // Commands from the bench
  input  wire logic [11:0]   fire,
  input  wire logic          av,
  input  wire logic          pend,
  input  wire logic          bc,
  // Link side
  output lefr_pkg::lefr_evt_t evt,
  output logic               ack_valid,
  output logic               async_pending,
  output logic               broadcast
);
  // One-cycle event pulses, quiet while in reset
  assign evt = rstn ? lefr_pkg::lefr_evt_t'(fire) : '0;
  // Send status and ack valid follow the bench
  assign ack_valid     = av;
  assign async_pending = pend;
  assign broadcast     = bc;
endmodule

// file: verification/test_link_event_flag_register.sv
// Bench for the link event flag register: register access and event scenarios.
`timescale 1ns/1ps
module test_link_event_flag_register;
  logic                clock = 1'b0;
  logic                rstn  = 1'b0;
  lefr_pkg::lefr_req_t req   = '0;
  logic [11:0]         fire  = 12'h000;
  logic                av    = 1'b0;
  logic                pend  = 1'b1;
  logic                bc    = 1'b0;
  logic [31:0]         rdata;
  logic [31:0]         rd_v;
  lefr_pkg::lefr_evt_t evt;
  logic                ack_valid, async_pending, broadcast, async_send_en, retry_arb;
  logic                force_busy_ack, discard_packet, async_queue_clear, irq;
  logic                selfid_capture_enable, trigger_size_enable, fb, dp, iq, ra;
  int                  miscompares = 0;
  int                  comparisons = 0;
  // Event index into the carrier and the flag bit it sets
  int                  ev_i [11] = '{11, 10, 9, 7, 6, 5, 4, 3, 2, 1, 0};
  int                  ev_b [11] = '{3, 4, 5, 6, 7, 8, 11, 12, 12, 14, 15};

  always #2 clock = ~clock;

  lefr_link_model link_u (.clock(clock), .rstn(rstn), .fire(fire), .av(av), .pend(pend),
    .bc(bc), .evt(evt),
    .ack_valid(ack_valid), .async_pending(async_pending), .broadcast(broadcast));

  lefr_flags dut_u (.clock(clock), .rstn(rstn), .req(req), .rdata(rdata), .evt(evt),
    .ack_valid(ack_valid), .async_pending(async_pending), .broadcast(broadcast),
    .async_send_en(async_send_en), .retry_arb(retry_arb), .force_busy_ack(force_busy_ack),
    .discard_packet(discard_packet), .async_queue_clear(async_queue_clear),
    .selfid_capture_enable(selfid_capture_enable),
    .trigger_size_enable(trigger_size_enable), .irq(irq));

  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Register port cycles
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge clock);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    rd_v = rdata;
  endtask

  // One-cycle event pulse; outputs snapped in the cycle after
  task pulse(input int i);
    @(posedge clock);
    fire <= 12'h001 << i;
    @(posedge clock);
    fire <= 12'h000;
    #1;
    fb = force_busy_ack;
    dp = discard_packet;
    iq = irq;
    ra = retry_arb;
  endtask

  task summarize();
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #20000;
    miscompares++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    chk(async_send_en, 1'b1);
    rd(lefr_pkg::OFS_FLAGS);
    chk(rd_v, lefr_pkg::FLAGS_RESET);
    rd(lefr_pkg::OFS_MASK);
    chk(rd_v, lefr_pkg::MASK_RESET);
    rd(8'h10);
    chk(rd_v, 32'h0000_0000);
    wr(lefr_pkg::OFS_MASK, 32'hffff_ffff);
    rd(lefr_pkg::OFS_MASK);
    chk(rd_v, lefr_pkg::FLAG_IMPL);
    wr(lefr_pkg::OFS_MASK, 32'h0000_4100);
    // Each event but the block arrival sets its flag, which stays until written with a one
    for (int k = 0; k < 11; k++) begin
      pulse(ev_i[k]);
      rd(lefr_pkg::OFS_FLAGS);
      chk(rd_v[ev_b[k]], 1'b1);
      wr(lefr_pkg::OFS_FLAGS, lefr_pkg::FLAG_IMPL);
      rd(lefr_pkg::OFS_FLAGS);
      chk(rd_v, 32'h0000_0000);
    end
    chk(async_send_en, 1'b0);
    rd(lefr_pkg::OFS_STATUS);
    chk(rd_v[lefr_pkg::BIT_ERR_STATE], 1'b1);
    wr(lefr_pkg::OFS_CTRL, 32'h0000_0008);
    #1;
    chk(async_queue_clear, 1'b1);
    @(posedge clock);
    #1;
    chk(async_send_en, 1'b1);
    // Masked and unmasked events against the interrupt line
    pulse(1);
    chk({fb, iq}, 2'b11);
    pulse(0);
    chk(dp, 1'b1);
    wr(lefr_pkg::OFS_FLAGS, lefr_pkg::FLAG_IMPL);
    rd(lefr_pkg::OFS_FLAGS);
    chk(rd_v, 32'h0000_0000);
    chk(irq, 1'b0);
    pulse(4);
    chk(iq, 1'b0);
    pulse(5);
    chk(iq, 1'b1);
    wr(lefr_pkg::OFS_FLAGS, lefr_pkg::FLAG_IMPL);
    // Packet arrival during self-ID is held until the bus reset ends
    pulse(11);
    pulse(7);
    rd(lefr_pkg::OFS_FLAGS);
    chk(rd_v[lefr_pkg::BIT_RX_BLOCK], 1'b0);
    pulse(10);
    rd(lefr_pkg::OFS_FLAGS);
    chk(rd_v[6:4], 3'h5);
    wr(lefr_pkg::OFS_FLAGS, lefr_pkg::FLAG_IMPL);
    // Control bits and block arrival with trigger size on
    wr(lefr_pkg::OFS_CTRL, 32'h0000_0006);
    rd(lefr_pkg::OFS_CTRL);
    chk(rd_v, 32'h0000_0006);
    chk({selfid_capture_enable, trigger_size_enable}, 2'b11);
    pulse(8);
    rd(lefr_pkg::OFS_FLAGS);
    chk(rd_v[lefr_pkg::BIT_RX_BLOCK], 1'b1);
    // Lost arbitration only on a directed async send with ack valid low
    pulse(9);
    chk(ra, 1'b1);
    @(posedge clock);
    bc <= 1'b1;
    pulse(9);
    chk(ra, 1'b0);
    @(posedge clock);
    bc <= 1'b0;
    av <= 1'b1;
    pulse(9);
    chk(ra, 1'b0);
    rd(lefr_pkg::OFS_STATUS);
    chk(rd_v[lefr_pkg::BIT_ACK_VALID], 1'b1);
    @(posedge clock);
    av <= 1'b0;
    pend <= 1'b0;
    pulse(9);
    chk(ra, 1'b0);
    summarize();
  end
endmodule
